//--- rtl/twx_pkg.sv
// Purpose: Constants for the table-write and subtract execution block.
// Assumes: 16-bit instruction words, four one-clock phases per instruction cycle.
// Notes: Behaviour list follows.
// Behaviour
// - Access bit zero resolves file in access bank.
// - Table write copies latch into selected holding register.
// - Table pointer is 21-bit byte address.
// - Pointer bit zero picks low or high byte.
// - Four pointer modes, pre-increment selects updated pointer.
// - Decode table-write opcode with two-bit mode field.
// - Holding registers keep bytes until flash commit.
// - Extended set, access, file<=95 uses indexed offset.
package twx_pkg;
	localparam int PTR_W = 21;
	localparam int HOLD_N = 8;
	localparam int HOLD_SEL_W = 3;
	localparam logic [13:0] TW_PREFIX = 14'h0003;
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_POST_INC = 2'h1;
	localparam logic [1:0] MODE_POST_DEC = 2'h2;
	localparam logic [1:0] MODE_PRE_INC = 2'h3;
	localparam logic [7:0] SUB_LIT_OP = 8'h08;
	localparam logic [5:0] SUB_FILE_OP = 6'h17;
	localparam logic [7:0] INDEXED_MAX = 8'h5F;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	localparam logic [PTR_W-1:0] PTR_RESET = 21'h000000;
	localparam logic [7:0] HOLD_RESET = 8'hFF;
	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} twx_phase_type;
endpackage

//--- rtl/twx_hold_byte.sv
// Purpose: One holding register byte of the write buffer.
// Assumes: Load strobe is one cycle wide.
// Notes: Cleared to erased value by the commit strobe unless load is high in the same cycle.
`timescale 1ns/1ns
module twx_hold_byte (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic load,
	input wire logic clear,
	input wire logic [7:0] din,
	// Stored value
	output logic [7:0] dout
);
	logic [7:0] val_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			val_q <= twx_pkg::HOLD_RESET;
		else if (load)
			val_q <= din;
		else if (clear)
			val_q <= twx_pkg::HOLD_RESET;
	end
	assign dout = val_q;
endmodule

//--- rtl/twx_exec.sv
// Purpose: Executes table-write and subtract instructions in four phases.
// Assumes: instr is stable for a whole instruction cycle starting at phase PH_Q1.
// Notes: Data memory access is outside; this block forms the address.
`timescale 1ns/1ns
module twx_exec (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Instruction stream
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	output logic instr_ready,
	// Core state
	input wire logic [7:0] acc,
	input wire logic [7:0] table_latch,
	input wire logic [3:0] bank_select_register,
	input wire logic [11:0] fsr2,
	input wire logic ext_set_en,
	input wire logic [7:0] file_data,
	// Table pointer load from core
	input wire logic ptr_load,
	input wire logic [20:0] ptr_load_val,
	// Flash commit consumes the holding registers
	input wire logic commit,
	// Results
	output logic [20:0] table_pointer,
	output logic [63:0] hold_bytes,
	output logic [11:0] file_addr,
	output logic [7:0] sub_result,
	output logic sub_to_file,
	output logic sub_carry,
	output logic sub_zero,
	output logic sub_neg,
	output logic sub_ovf,
	output logic sub_dc,
	output logic sub_done,
	output logic table_write_instr
);
	twx_pkg::twx_phase_type ph_q;
	logic [20:0] ptr_q, ptr_d;
	logic [7:0] res_q;
	logic [11:0] addr_q;
	logic c_q, z_q, n_q, ov_q, dc_q, dst_q, done_q, tw_q;

	// Opcode decode.
	wire is_tw = instr[15:2] == twx_pkg::TW_PREFIX;
	wire [1:0] tw_mode = instr[1:0];
	wire is_sub_lit = instr[15:8] == twx_pkg::SUB_LIT_OP;
	wire is_sub_file = instr[15:10] == twx_pkg::SUB_FILE_OP;
	wire acc_bit = instr[8];
	wire [7:0] fop = instr[7:0];

	// Address resolution for the file operand.
	wire use_indexed = !acc_bit && ext_set_en && fop <= twx_pkg::INDEXED_MAX;
	wire [11:0] addr_indexed = fsr2 + {4'h0, fop};
	wire [11:0] addr_access = {(fop[7] ? twx_pkg::ACCESS_HI_BANK : 4'h0), fop};
	wire [11:0] addr_banked = {bank_select_register, fop};
	wire [11:0] addr_sel = acc_bit ? addr_banked :
		(use_indexed ? addr_indexed : addr_access);

	// Subtraction: minuend minus accumulator, done as minuend + ~acc + 1.
	wire [7:0] minuend = is_sub_lit ? fop : file_data;
	wire [8:0] diff = {1'b0, minuend} + {1'b0, ~acc} + 9'h001;
	wire [4:0] dlow = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
	wire ovf = (minuend[7] != acc[7]) && (diff[7] != minuend[7]);

	// Pointer update; pre-increment selects the holding byte with the new value.
	wire [20:0] ptr_inc = ptr_q + 21'h000001;
	wire [20:0] ptr_dec = ptr_q - 21'h000001;
	wire [20:0] ptr_sel = (tw_mode == twx_pkg::MODE_PRE_INC) ? ptr_inc : ptr_q;
	// Bit zero is the byte lane of the program word: 0 low byte, 1 high byte.
	wire byte_hi = ptr_sel[0];
	wire [2:0] hold_idx = {ptr_sel[2:1], byte_hi};

	// The table write takes a second instruction cycle; the stream waits.
	logic second_q;
	wire tw_fire = instr_valid && is_tw && !second_q && ph_q == twx_pkg::PH_Q4;
	assign instr_ready = (ph_q == twx_pkg::PH_Q4) && !(is_tw && !second_q);

	always_comb begin
		ptr_d = ptr_q;
		unique case (tw_mode)
			twx_pkg::MODE_NONE: ptr_d = ptr_q;
			twx_pkg::MODE_POST_INC: ptr_d = ptr_inc;
			twx_pkg::MODE_POST_DEC: ptr_d = ptr_dec;
			twx_pkg::MODE_PRE_INC: ptr_d = ptr_inc;
		endcase
	end

	// Holding register bank.
	genvar gi;
	generate
		for (gi = 0; gi < twx_pkg::HOLD_N; gi++) begin : g_hold
			wire ld = tw_fire && hold_idx == 3'(gi);
			twx_hold_byte u_byte (
				.clk(clk),
				.rst(rst),
				.load(ld),
				.clear(commit),
				.din(table_latch),
				.dout(hold_bytes[gi*8 +: 8])
			);
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ph_q <= twx_pkg::PH_Q1;
		else
			ph_q <= twx_phase_type_next(ph_q);
	end

	function automatic twx_pkg::twx_phase_type twx_phase_type_next(twx_pkg::twx_phase_type p);
		unique case (p)
			twx_pkg::PH_Q1: return twx_pkg::PH_Q2;
			twx_pkg::PH_Q2: return twx_pkg::PH_Q3;
			twx_pkg::PH_Q3: return twx_pkg::PH_Q4;
			twx_pkg::PH_Q4: return twx_pkg::PH_Q1;
		endcase
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			second_q <= 1'b0;
		else if (ph_q == twx_pkg::PH_Q4)
			second_q <= tw_fire;
	end

	// The 21-bit pointer covers every byte of a two megabyte space.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ptr_q <= twx_pkg::PTR_RESET;
		else if (tw_fire)
			ptr_q <= ptr_d;
		else if (ptr_load)
			ptr_q <= ptr_load_val;
	end

	// A subtract is taken at the Q4 edge of its instruction cycle, like any other instruction.
	wire sub_take = instr_valid && ph_q == twx_pkg::PH_Q4 && (is_sub_lit || is_sub_file);
	wire [11:0] addr_next = is_sub_file ? addr_sel : 12'h000;
	wire zero_next = diff[7:0] == 8'h00;
	wire dst_next = is_sub_file && instr[9];

	// Each result stands until the next subtract, so the core may pick it up late.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			res_q <= 8'h00;
		else if (sub_take)
			res_q <= diff[7:0];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			addr_q <= 12'h000;
		else if (sub_take)
			addr_q <= addr_next;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			c_q <= 1'b0;
		else if (sub_take)
			c_q <= diff[8];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			z_q <= 1'b0;
		else if (sub_take)
			z_q <= zero_next;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			n_q <= 1'b0;
		else if (sub_take)
			n_q <= diff[7];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ov_q <= 1'b0;
		else if (sub_take)
			ov_q <= ovf;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			dc_q <= 1'b0;
		else if (sub_take)
			dc_q <= dlow[4];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			dst_q <= 1'b0;
		else if (sub_take)
			dst_q <= dst_next;
	end

	// Both strobes are one cycle wide; the core must catch them in that cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_q <= 1'b0;
			tw_q <= 1'b0;
		end else begin
			done_q <= sub_take;
			tw_q <= tw_fire;
		end
	end

	assign table_pointer = ptr_q;
	assign file_addr = addr_q;
	assign sub_result = res_q;
	assign sub_to_file = dst_q;
	assign sub_carry = c_q;
	assign sub_zero = z_q;
	assign sub_neg = n_q;
	assign sub_ovf = ov_q;
	assign sub_dc = dc_q;
	assign sub_done = done_q;
	assign table_write_instr = tw_q;
endmodule

//--- verif/twx_exec_sva.sv
// Purpose: Port checks for twx_exec.
// Assumes: One clock, reset active high.
// Notes: Bound after the module.
`timescale 1ns/1ns
module twx_exec_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched ports
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic instr_ready,
	input wire logic [7:0] acc,
	input wire logic [3:0] bank_select_register,
	input wire logic [11:0] fsr2,
	input wire logic ext_set_en,
	input wire logic [20:0] table_pointer,
	input wire logic [11:0] file_addr,
	input wire logic [7:0] sub_result,
	input wire logic sub_carry,
	input wire logic sub_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire [7:0] f = instr[7:0];
	wire tk = instr_valid && instr_ready;
	wire lw = tk && instr[15:8] == twx_pkg::SUB_LIT_OP;
	wire wf = tk && instr[15:10] == twx_pkg::SUB_FILE_OP;
	wire tw = tk && instr[15:2] == twx_pkg::TW_PREFIX;
	wire ix = !instr[8] && ext_set_en && f <= twx_pkg::INDEXED_MAX;
	wire [11:0] ba = {bank_select_register, f};
	wire [11:0] aa = {{4{f[7]}}, f};
	wire [11:0] xa = fsr2 + {4'h0, f};
	sequence pulse; sub_done ##1 !sub_done; endsequence
	// Ready only rises in Q4, so three quiet cycles must follow every take.
	AST_SPACE: assert property (instr_ready |=> !instr_ready [*3])
		else $error("take too soon");
	AST_DONE: assert property (lw || wf |=> pulse)
		else $error("no done pulse");
	AST_CAUSE: assert property (sub_done |-> $past(lw || wf))
		else $error("stray done");
	AST_DIFF: assert property (lw |=> sub_result == $past(f - acc))
		else $error("bad difference");
	AST_CARRY: assert property (lw |=> sub_carry == $past(f >= acc))
		else $error("bad carry");
	AST_BANK: assert property (wf && instr[8] |=> file_addr == $past(ba))
		else $error("bad banked address");
	AST_ACC: assert property (wf && !instr[8] && !ix |=> file_addr == $past(aa))
		else $error("bad access address");
	AST_IDX: assert property (wf && ix |=> file_addr == $past(xa))
		else $error("bad indexed address");
	// The pointer moves at the first Q4 of a table write, four edges before the take.
	AST_INC: assert property (tw && instr[1:0] == twx_pkg::MODE_POST_INC |->
		table_pointer == $past(table_pointer, 4) + 21'h000001)
		else $error("bad increment");
	AST_DEC: assert property (tw && instr[1:0] == twx_pkg::MODE_POST_DEC |->
		table_pointer == $past(table_pointer, 4) - 21'h000001)
		else $error("bad decrement");
endmodule
bind twx_exec twx_exec_sva u_twx_exec_sva (.clk, .rst, .instr_valid, .instr, .instr_ready,
	.acc, .bank_select_register, .fsr2, .ext_set_en, .table_pointer, .file_addr,
	.sub_result, .sub_carry, .sub_done);

//--- verif/test_twx_exec.sv
// Purpose: Self-checking bench for twx_exec.
// Assumes: Inputs change at the falling edge.
// Notes: Ends in wrap_up.
`timescale 1ns/1ns
module test_twx_exec;
	logic clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, ext_set_en = 1'b0;
	logic ptr_load = 1'b0, commit = 1'b0, instr_ready, sub_to_file, sub_carry;
	logic sub_zero, sub_neg, sub_done, sub_ovf, sub_dc, table_write_instr;
	logic done_seen = 1'b0, tw_seen = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [7:0] acc = 8'h00, table_latch = 8'h00, file_data = 8'h01, sub_result;
	logic [3:0] bank_select_register = 4'h3;
	logic [11:0] fsr2 = 12'h120, file_addr;
	logic [20:0] ptr_load_val = 21'h000000, table_pointer;
	logic [63:0] hold_bytes;
	int errors = 0, n_checks = 0;
	twx_exec u_twx_exec (.clk, .rst, .instr_valid, .instr, .instr_ready, .acc, .table_latch,
		.bank_select_register, .fsr2, .ext_set_en, .file_data, .ptr_load, .ptr_load_val,
		.commit, .table_pointer, .hold_bytes, .file_addr, .sub_result, .sub_to_file,
		.sub_carry, .sub_zero, .sub_neg, .sub_ovf, .sub_dc, .sub_done,
		.table_write_instr);
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up;
		if (errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic run(input logic [15:0] op);
		int i;
		instr = op;
		instr_valid = 1'b1;
		i = 0;
		tw_seen = 1'b0;
		// Ready is combinational, so it is read once settled after the falling edge.
		#1;
		while (instr_ready !== 1'b1 && i < 12) begin
			@(negedge clk);
			#1;
			i++;
			tw_seen = tw_seen | table_write_instr;
		end
		// The done strobe stands only in the cycle after the take edge.
		@(negedge clk);
		done_seen = sub_done;
		instr_valid = 1'b0;
		@(negedge clk);
	endtask
	task automatic load(input logic [20:0] v);
		ptr_load_val = v;
		ptr_load = 1'b1;
		@(negedge clk);
		ptr_load = 1'b0;
	endtask
	task automatic t_lit;
		logic [7:0] w [4] = '{8'h01, 8'h02, 8'h03, 8'h82};
		foreach (w[k]) begin
			acc = w[k];
			run(16'h0802);
			chk("diff", sub_result, 8'(8'h02 - w[k]));
			chk("carry", sub_carry, w[k] <= 8'h02);
			chk("zero", sub_zero, w[k] == 8'h02);
			chk("done", done_seen, 1'b1);
			chk("twflag", tw_seen, 1'b0);
			// Two minus a negative 126 leaves the signed range.
			chk("ovf", sub_ovf, w[k] == 8'h82);
			chk("dc", sub_dc, w[k][3:0] <= 4'h2);
		end
	endtask
	task automatic t_file;
		logic [9:0] c [5] = '{10'h220, 10'h020, 10'h090, 10'h15F, 10'h160};
		logic [11:0] x [5] = '{12'h320, 12'h020, 12'hF90, 12'h17F, 12'h060};
		acc = 8'h02;
		foreach (c[k]) begin
			ext_set_en = c[k][8];
			run({6'h17, k[0], c[k][9], c[k][7:0]});
			chk("addr", file_addr, x[k]);
			chk("dest", sub_to_file, k[0]);
			chk("diff", sub_result, 8'hFF);
			chk("neg", sub_neg, 1'b1);
		end
	endtask
	task automatic t_tw;
		logic [39:0] s [4] = '{40'h1_55_6_00A357, 40'h3_34_0_00A358, 40'h2_12_0_00A357,
			40'h0_77_7_00A357};
		load(21'h00A356);
		foreach (s[k]) begin
			table_latch = s[k][35:28];
			run({14'h0003, s[k][37:36]});
			chk("ptr", table_pointer, s[k][20:0]);
			chk("hold", hold_bytes[8*s[k][27:24] +: 8], s[k][35:28]);
			chk("twflag", tw_seen, 1'b1);
		end
		chk("kept", hold_bytes[55:48], 8'h55);
		commit = 1'b1;
		@(negedge clk);
		commit = 1'b0;
		chk("clear", hold_bytes, {8{8'hFF}});
		load(21'h1FFFFF);
		run(16'h000D);
		chk("wrap", table_pointer, 21'h000000);
		chk("top", hold_bytes[63:56], 8'h77);
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		errors++;
		wrap_up;
	end
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		chk("ptr0", table_pointer, 21'h000000);
		chk("hold0", hold_bytes, {8{8'hFF}});
		t_lit;
		t_file;
		t_tw;
		wrap_up;
	end
endmodule
